// ==== rtl/bjc_cfg.svh ====
// decoder constants: flags, opcodes, lengths, states
// assumes: included by bare name
`ifndef BJC_CFG_SVH
`define BJC_CFG_SVH
// flag bit positions
`define BJC_FS 7
`define BJC_FZ 6
`define BJC_FH 4
`define BJC_FP 2
`define BJC_FN 1
`define BJC_FC 0
// prefix bytes; 00 means no prefix
`define BJC_PFX_NONE 8'h00
`define BJC_PFX_CB 8'hCB
`define BJC_PFX_ED 8'hED
// opcodes handled by exact match
`define BJC_OP_DIGL 8'h6F
`define BJC_OP_DIGR 8'h67
`define BJC_OP_NMI_RTN 8'h45
`define BJC_OP_IRQ_RTN 8'h4D
`define BJC_OP_AJMP 8'hC3
`define BJC_OP_CALL 8'hCD
`define BJC_OP_SRTN 8'hC9
`define BJC_OP_RJMP 8'h18
`define BJC_OP_DBNZ 8'h10
// register code that means the byte at HL
`define BJC_REG_MEM 3'h6
// instruction lengths and stack step
`define BJC_LEN1 16'h0001
`define BJC_LEN2 16'h0002
`define BJC_LEN3 16'h0003
`define BJC_STK_STEP 16'h0002
// clock states, one state per mclk cycle with ce high
`define BJC_T_DIG 5'h12
`define BJC_T_BIT_R 5'h08
`define BJC_T_BIT_M 5'h0C
`define BJC_T_SET_R 5'h08
`define BJC_T_SET_M 5'h0F
`define BJC_T_AJMP 5'h0A
`define BJC_T_RJMP_NO 5'h07
`define BJC_T_RJMP_YES 5'h0C
`define BJC_T_DBNZ_NO 5'h08
`define BJC_T_DBNZ_YES 5'h0D
`define BJC_T_CALL_NO 5'h0A
`define BJC_T_CALL_YES 5'h11
`define BJC_T_CRTN_NO 5'h05
`define BJC_T_CRTN_YES 5'h0B
`define BJC_T_SRTN 5'h0A
`define BJC_T_IRTN 5'h0E
`define BJC_T_RST 5'h0B
`define BJC_T_IOC 5'h0C
`define BJC_T_BLK 5'h10
`define BJC_T_BLK_RPT 5'h15
`define BJC_T_BAD 5'h04
`endif

// ==== rtl/bjc_pkg.sv ====
// decoder types
// assumes: header on the include path
package bjc_pkg;
    // sequencer phase, one-hot
    typedef enum logic [1:0] {BJC_IDLE = 2'h1, BJC_RUN = 2'h2} bjc_phase_e;
    // top two opcode bits after the CB prefix
    typedef enum logic [1:0] {BJC_BT = 2'h1, BJC_BC = 2'h2,
        BJC_BS = 2'h3} bjc_bitop_e;
    // prefix, opcode, operand word {hi,lo}
    typedef struct packed {
        logic [7:0] pfx;
        logic [7:0] op;
        logic [15:0] imm;
    } bjc_ins_s;
    // processor state seen at instruction start
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] f;
        logic [7:0] b;
        logic [15:0] hl;
        logic [15:0] pc;
        logic [15:0] sp;
        logic ien2;
    } bjc_cpu_s;
    // register file write
    typedef struct packed {
        logic en;
        logic [2:0] sel;
        logic [7:0] data;
    } bjc_regw_s;
    // memory byte write
    typedef struct packed {
        logic en;
        logic [15:0] addr;
        logic [7:0] data;
    } bjc_memw_s;
    // everything an instruction changes
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] a;
        logic [7:0] f;
        logic [7:0] b;
        logic [15:0] hl;
        logic [15:0] sp;
        bjc_regw_s regw;
        bjc_memw_s memw;
        logic push_en;
        logic [15:0] push_data;
        logic pop_en;
        logic port_wr_en;
        logic [7:0] port_wr_data;
        logic ien_ld;
        logic ien_val;
        logic bad;
    } bjc_outc_s;
    // whole decoder state
    typedef struct packed {
        bjc_phase_e phase;
        logic [4:0] cnt;
        logic done;
        logic [4:0] tst;
        bjc_outc_s outc;
    } bjc_state_s;
endpackage

// ==== rtl/bjc_cond.sv ====
// condition field evaluator
// assumes: flag layout of the header
`include "bjc_cfg.svh"
module bjc_cond (
    input wire logic [2:0] cond,
    input wire logic [7:0] flags,
    output logic met
);
    logic sel; // flag picked by the upper two bits

    // even codes test for a clear flag, odd codes for a set flag
    always_comb
    begin
        unique case (cond[2:1])
            2'h0: sel = flags[`BJC_FZ];
            2'h1: sel = flags[`BJC_FC];
            2'h2: sel = flags[`BJC_FP];
            2'h3: sel = flags[`BJC_FS];
        endcase
        met = ~(sel ^ cond[0]);
    end
endmodule

// ==== rtl/bjc_bitop.sv ====
// bit test, set and clear on one byte
// assumes: operand already read
module bjc_bitop (
    input wire bjc_pkg::bjc_bitop_e kind,
    input wire logic [2:0] bitn,
    input wire logic [7:0] val,
    output logic [7:0] result,
    output logic bit_val
);
    assign bit_val = val[bitn];

    // each bit is forced only when selected; test passes the byte through
    genvar i;
    for (i = 0; i < 8; i++)
    begin : g_bit
        assign result[i] = (bitn == 3'(i) && kind != bjc_pkg::BJC_BT)
                           ? (kind == bjc_pkg::BJC_BS) : val[i];
    end
endmodule

// ==== rtl/bjc_decoder.sv ====
// decode and execute of bit, jump, call, return and port ops
// assumes: bytes fetched; caller feeds operands and the stack word,
// and applies the registered outcome on done
`include "bjc_cfg.svh"
// Operation
// - digit rotates ED 6F/67 take 18 states
// - accumulator upper nibble kept during digit rotates
// - bit test: Z inverse bit, H set, N clear
// - bit clear is set form with top 10
// - bit clear: no flags, set's timing
// - condition field selects eight flag tests
// - conditional absolute jump: 10 states either way
// - relative jump: 7 states fail, 12 taken
// - displacement is signed two's complement
// - target is start plus two plus displacement
// - call: 10 false, push high then low, 17
// - conditional return: 5 false, pop 11 true
// - nonmaskable return restores enable, 14 states
// - restart pushes, jumps to t times eight
// - port input code 110 updates flags only
// - block repeat: 21 states looping, 16 last
// - block transfer: Z set when B reaches 0
// - block transfer: N copies data bit seven
module bjc_decoder (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic ins_valid,
    output logic ins_ready,
    input wire bjc_pkg::bjc_ins_s ins,
    input wire bjc_pkg::bjc_cpu_s cpu,
    input wire logic [7:0] opnd_rd,
    input wire logic [7:0] port_rd,
    input wire logic [15:0] stack_rd,
    output logic done,
    output logic [4:0] tstates,
    output bjc_pkg::bjc_outc_s outc
);
    bjc_pkg::bjc_state_s s_ff; // registered state
    bjc_pkg::bjc_state_s nxt_s; // next state
    bjc_pkg::bjc_outc_s dec; // decoded outcome
    logic [4:0] dec_t; // its length in clock states
    logic [7:0] op; // opcode byte
    logic [2:0] yf; // middle field: bit, condition, restart page
    logic [2:0] zf; // low field: register code
    logic [1:0] xf; // top field
    logic [2:0] cond_sel; // condition code
    logic met; // condition holds
    logic [7:0] bit_res; // operand after set or clear
    logic bit_val; // selected operand bit
    logic [15:0] disp; // sign-extended displacement
    logic [7:0] b_dec; // B minus one
    logic [7:0] blk_data; // byte moved by a block transfer
    logic [7:0] dig_a; // A after digit rotate
    logic [7:0] dig_m; // (HL) after digit rotate

    // flags from a result byte: S, Z and parity set, H and N cleared
    function automatic logic [7:0] szp(input logic [7:0] v,
                                       input logic [7:0] fin);
        logic [7:0] fo;
        fo = fin;
        fo[`BJC_FS] = v[7];
        fo[`BJC_FZ] = (v == 8'h00);
        fo[`BJC_FP] = ~^v;
        fo[`BJC_FH] = 1'b0;
        fo[`BJC_FN] = 1'b0;
        return fo;
    endfunction

    assign op = ins.op;
    assign yf = op[5:3];
    assign zf = op[2:0];
    assign xf = op[7:6];

    // relative forms carry a two-bit code; others use the full field
    assign cond_sel = (xf == 2'h0) ? {1'b0, op[4:3]} : yf;

    bjc_cond u_cond (
        .cond(cond_sel),
        .flags(cpu.f),
        .met(met)
    );

    // top bits pick set or clear
    bjc_bitop u_bitop (
        .kind(bjc_pkg::bjc_bitop_e'(xf)),
        .bitn(yf),
        .val(opnd_rd),
        .result(bit_res),
        .bit_val(bit_val)
    );

    assign disp = {{8{ins.imm[7]}}, ins.imm[7:0]};
    assign b_dec = cpu.b - 8'h01;
    // output moves the (HL) byte, input moves the port byte
    assign blk_data = op[0] ? opnd_rd : port_rd;

    assign dig_a = (op == `BJC_OP_DIGL) ? {cpu.a[7:4], opnd_rd[7:4]}
                                        : {cpu.a[7:4], opnd_rd[3:0]};
    assign dig_m = (op == `BJC_OP_DIGL) ? {opnd_rd[3:0], cpu.a[3:0]}
                                        : {cpu.a[3:0], opnd_rd[7:4]};

    // decode: outcome and state count
    always_comb
    begin
        // defaults: nothing written; unmatched forms stay bad
        dec = '0;
        dec.pc = cpu.pc + `BJC_LEN1;
        dec.a = cpu.a;
        dec.f = cpu.f;
        dec.b = cpu.b;
        dec.hl = cpu.hl;
        dec.sp = cpu.sp;
        dec.bad = 1'b1;
        dec_t = `BJC_T_BAD;
        if (ins.pfx == `BJC_PFX_CB)
        begin
            dec.pc = cpu.pc + `BJC_LEN2;
            if (xf == 2'h1)
            begin
                dec.bad = 1'b0;
                dec.f[`BJC_FZ] = ~bit_val;
                dec.f[`BJC_FH] = 1'b1;
                dec.f[`BJC_FN] = 1'b0;
                dec_t = (zf == `BJC_REG_MEM) ? `BJC_T_BIT_M : `BJC_T_BIT_R;
            end
            else if (xf[1])
            begin
                // set and clear share timing, no flags
                dec.bad = 1'b0;
                if (zf == `BJC_REG_MEM)
                begin
                    // the byte at HL is written back
                    dec.memw.en = 1'b1;
                    dec.memw.addr = cpu.hl;
                    dec.memw.data = bit_res;
                    dec_t = `BJC_T_SET_M;
                end
                else
                begin
                    // a register is written back
                    dec.regw.en = 1'b1;
                    dec.regw.sel = zf;
                    dec.regw.data = bit_res;
                    dec_t = `BJC_T_SET_R;
                end
            end
        end
        else if (ins.pfx == `BJC_PFX_ED)
        begin
            dec.pc = cpu.pc + `BJC_LEN2;
            if (op == `BJC_OP_DIGL || op == `BJC_OP_DIGR)
            begin
                dec.bad = 1'b0;
                dec.a = dig_a;
                dec.f = szp(dig_a, cpu.f);
                dec.memw.en = 1'b1;
                dec.memw.addr = cpu.hl;
                dec.memw.data = dig_m;
                dec_t = `BJC_T_DIG;
            end
            else if (op == `BJC_OP_NMI_RTN || op == `BJC_OP_IRQ_RTN)
            begin
                // both pop the return address
                dec.bad = 1'b0;
                dec.pop_en = 1'b1;
                dec.pc = stack_rd;
                dec.sp = cpu.sp + `BJC_STK_STEP;
                dec_t = `BJC_T_IRTN;
                dec.ien_ld = (op == `BJC_OP_NMI_RTN);
                dec.ien_val = cpu.ien2;
            end
            else if (xf == 2'h1 && zf == 3'h0)
            begin
                // port input, code 110 flags only
                dec.bad = 1'b0;
                dec.f = szp(port_rd, cpu.f);
                dec.regw.en = (yf != `BJC_REG_MEM);
                dec.regw.sel = yf;
                dec.regw.data = port_rd;
                dec_t = `BJC_T_IOC;
            end
            else if (xf == 2'h1 && zf == 3'h1)
            begin
                // port output of the selected register
                dec.bad = 1'b0;
                dec.port_wr_en = 1'b1;
                dec.port_wr_data = opnd_rd;
                dec_t = `BJC_T_IOC;
            end
            else if (op[7:5] == 3'h5 && op[2:1] == 2'h1)
            begin
                // block transfer: bit3 steps down, bit4 repeats
                dec.bad = 1'b0;
                dec.b = b_dec;
                dec.hl = op[3] ? cpu.hl - `BJC_LEN1 : cpu.hl + `BJC_LEN1;
                dec.memw.en = ~op[0];
                dec.memw.addr = cpu.hl;
                dec.memw.data = port_rd;
                dec.port_wr_en = op[0];
                dec.port_wr_data = opnd_rd;
                dec.f[`BJC_FZ] = (b_dec == 8'h00);
                dec.f[`BJC_FN] = blk_data[7];
                dec_t = `BJC_T_BLK;
                if (op[4] && b_dec != 8'h00)
                begin
                    dec.pc = cpu.pc;
                    dec_t = `BJC_T_BLK_RPT;
                end
            end
        end
        else if (ins.pfx == `BJC_PFX_NONE)
        begin
            if (op == `BJC_OP_AJMP || (xf == 2'h3 && zf == 3'h2))
            begin
                // absolute jump, 10 states either way
                dec.bad = 1'b0;
                dec.pc = (met || op == `BJC_OP_AJMP) ? ins.imm
                                                   : cpu.pc + `BJC_LEN3;
                dec_t = `BJC_T_AJMP;
            end
            else if (op == `BJC_OP_RJMP)
            begin
                dec.bad = 1'b0;
                dec.pc = cpu.pc + `BJC_LEN2 + disp;
                dec_t = `BJC_T_RJMP_YES;
            end
            else if (xf == 2'h0 && op[5] && zf == 3'h0)
            begin
                dec.bad = 1'b0;
                dec.pc = met ? cpu.pc + `BJC_LEN2 + disp
                             : cpu.pc + `BJC_LEN2;
                dec_t = met ? `BJC_T_RJMP_YES : `BJC_T_RJMP_NO;
            end
            else if (op == `BJC_OP_DBNZ)
            begin
                // count B down, branch while it is nonzero
                dec.bad = 1'b0;
                dec.b = b_dec;
                dec.pc = (b_dec != 8'h00) ? cpu.pc + `BJC_LEN2 + disp
                                          : cpu.pc + `BJC_LEN2;
                dec_t = (b_dec != 8'h00) ? `BJC_T_DBNZ_YES
                                         : `BJC_T_DBNZ_NO;
            end
            else if (op == `BJC_OP_CALL || (xf == 2'h3 && zf == 3'h4))
            begin
                // call pushes return, high byte first
                dec.bad = 1'b0;
                dec.pc = cpu.pc + `BJC_LEN3;
                dec_t = `BJC_T_CALL_NO;
                if (op == `BJC_OP_CALL || met)
                begin
                    dec.push_en = 1'b1;
                    dec.push_data = cpu.pc + `BJC_LEN3;
                    dec.sp = cpu.sp - `BJC_STK_STEP;
                    dec.pc = ins.imm;
                    dec_t = `BJC_T_CALL_YES;
                end
            end
            else if (op == `BJC_OP_SRTN)
            begin
                // plain return pops low then high
                dec.bad = 1'b0;
                dec.pop_en = 1'b1;
                dec.pc = stack_rd;
                dec.sp = cpu.sp + `BJC_STK_STEP;
                dec_t = `BJC_T_SRTN;
            end
            else if (xf == 2'h3 && zf == 3'h0)
            begin
                dec.bad = 1'b0;
                dec_t = `BJC_T_CRTN_NO;
                if (met)
                begin
                    dec.pop_en = 1'b1;
                    dec.pc = stack_rd;
                    dec.sp = cpu.sp + `BJC_STK_STEP;
                    dec_t = `BJC_T_CRTN_YES;
                end
            end
            else if (xf == 2'h3 && zf == 3'h7)
            begin
                dec.bad = 1'b0;
                dec.push_en = 1'b1;
                dec.push_data = cpu.pc + `BJC_LEN1;
                dec.sp = cpu.sp - `BJC_STK_STEP;
                dec.pc = {8'h00, 2'h0, yf, 3'h0};
                dec_t = `BJC_T_RST;
            end
        end
    end

    // sequencer: holds the outcome until the state count is spent
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        unique case (s_ff.phase)
            bjc_pkg::BJC_IDLE:
            begin
                // accept and latch the outcome
                if (ins_valid)
                begin
                    nxt_s.outc = dec;
                    nxt_s.tst = dec_t;
                    nxt_s.cnt = dec_t - 5'h01;
                    nxt_s.phase = bjc_pkg::BJC_RUN;
                end
            end
            bjc_pkg::BJC_RUN:
            begin
                // count down, then flag done
                if (s_ff.cnt == 5'h00)
                begin
                    nxt_s.done = 1'b1;
                    nxt_s.phase = bjc_pkg::BJC_IDLE;
                end
                else
                begin
                    nxt_s.cnt = s_ff.cnt - 5'h01;
                end
            end
            default:
            begin
                // a corrupted phase code falls back to idle
                nxt_s.phase = bjc_pkg::BJC_IDLE;
            end
        endcase
    end

    // state register; ce low freezes everything, done included
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_ff <= '0;
            s_ff.phase <= bjc_pkg::BJC_IDLE;
        end
        else if (ce)
        begin
            s_ff <= nxt_s;
        end
    end

    // ready is combinational so a new instruction can follow done
    assign ins_ready = (s_ff.phase == bjc_pkg::BJC_IDLE);
    assign done = s_ff.done;
    assign tstates = s_ff.tst;
    assign outc = s_ff.outc;
endmodule

// ==== sim/bjc_bus_model.sv ====
// far side: byte at HL, port answer, stack word
// assumes: addresses settle before sampling
module bjc_bus_model (
    input wire logic [15:0] hl,
    input wire logic [15:0] sp,
    output logic [7:0] mem_byte,
    output logic [7:0] port_byte,
    output logic [15:0] stack_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // 256-byte window mirrored over the space keeps the model small
    logic [7:0] mem [256];
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i * 8'h25 + 8'h0B);
    end
    // byte at HL and a port answer that differs from it
    assign mem_byte = mem[hl[7:0]];
    assign port_byte = ~mem[hl[7:0] ^ 8'h5A];
    assign stack_word = {mem[8'(sp[7:0] + 8'h01)], mem[sp[7:0]]};
endmodule

// ==== sim/bjc_decoder_properties.sv ====
// checks of decoder outcome and timing
// assumes: bound into the decoder
`include "bjc_cfg.svh"
module bjc_decoder_properties (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic ins_valid,
    input wire logic ins_ready,
    input wire bjc_pkg::bjc_ins_s ins,
    input wire bjc_pkg::bjc_cpu_s cpu,
    input wire logic [7:0] opnd_rd,
    input wire logic [7:0] port_rd,
    input wire logic [15:0] stack_rd,
    input wire logic done,
    input wire logic [4:0] tstates,
    input wire bjc_pkg::bjc_outc_s outc
);
    // request seen at the previous edge
    typedef struct packed {
        logic acc;
        bjc_pkg::bjc_ins_s i;
        bjc_pkg::bjc_cpu_s c;
        logic [7:0] d;
        logic [7:0] p;
        logic [15:0] w;
    } bjc_seen_s;
    bjc_seen_s s_ff;
    logic [4:0] cnt_ff;
    logic acc, ed, cb, np, cc, m, mr;
    logic [7:0] op;
    logic [15:0] pc, rel;
    // condition field against the flag byte
    function automatic logic met(input logic [2:0] c, input logic [7:0] f);
        logic b;
        b = c[2] ? (c[1] ? f[`BJC_FS] : f[`BJC_FP])
            : (c[1] ? f[`BJC_FC] : f[`BJC_FZ]);
        return c[0] ? b : !b;
    endfunction
    assign acc = ce && ins_valid && ins_ready;
    assign op = s_ff.i.op;
    assign pc = s_ff.c.pc;
    assign ed = s_ff.acc && s_ff.i.pfx == 8'hED;
    assign cb = s_ff.acc && s_ff.i.pfx == 8'hCB;
    assign np = s_ff.acc && s_ff.i.pfx == 8'h00;
    assign cc = np && op[7:6] == 2'h3;
    assign m = met(op[5:3], s_ff.c.f);
    assign mr = met({1'b0, op[4:3]}, s_ff.c.f);
    assign rel = {{8{s_ff.i.imm[7]}}, s_ff.i.imm[7:0]};
    // counts enabled edges since accept; frozen once done is out
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_ff <= '0;
            cnt_ff <= 5'h00;
        end
        else
        begin
            s_ff <= {acc, ins, cpu, opnd_rd, port_rd, stack_rd};
            cnt_ff <= acc ? 5'h00 : cnt_ff + 5'(ce && !ins_ready);
        end
    end
    default clocking cb_clk @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    property p_dig;
        ed && (op == 8'h6F || op == 8'h67) |->
            tstates == 5'h12 && outc.a[7:4] == s_ff.c.a[7:4];
    endproperty
    a_dig: assert property (p_dig) else $error("digit rotate");
    property p_btst;
        cb && op[7:6] == 2'h1 |-> outc.f[`BJC_FZ] == !s_ff.d[op[5:3]]
            && outc.f[`BJC_FH] && !outc.f[`BJC_FN];
    endproperty
    a_btst: assert property (p_btst) else $error("bit test flags");
    property p_bclr;
        cb && op[7:6] == 2'h2 |-> outc.f == s_ff.c.f
            && tstates == (op[2:0] == 3'h6 ? 5'h0F : 5'h08);
    endproperty
    a_bclr: assert property (p_bclr) else $error("bit clear");
    property p_abs;
        cc && op[2:0] == 3'h2 |-> tstates == 5'h0A
            && outc.pc == (m ? s_ff.i.imm : pc + 16'h0003);
    endproperty
    a_abs: assert property (p_abs) else $error("absolute jump");
    property p_rel;
        np && op[7:5] == 3'h1 && op[2:0] == 3'h0 |-> tstates == (mr ? 5'h0C
            : 5'h07) && outc.pc == pc + 16'h0002 + (mr ? rel : 16'h0000);
    endproperty
    a_rel: assert property (p_rel) else $error("relative");
    property p_call;
        cc && op[2:0] == 3'h4 |-> tstates == (m ? 5'h11 : 5'h0A)
            && outc.push_en == m && (!m || outc.push_data == pc + 16'h0003);
    endproperty
    a_call: assert property (p_call) else $error("call");
    property p_cret;
        cc && op[2:0] == 3'h0 |-> tstates == (m ? 5'h0B : 5'h05)
            && outc.pc == (m ? s_ff.w : pc + 16'h0001);
    endproperty
    a_cret: assert property (p_cret) else $error("return");
    property p_nret;
        ed && op == 8'h45 |-> tstates == 5'h0E && outc.ien_ld
            && outc.ien_val == s_ff.c.ien2 && outc.pc == s_ff.w;
    endproperty
    a_nret: assert property (p_nret) else $error("nmi return");
    property p_port;
        ed && op[7:6] == 2'h1 && op[2:0] == 3'h0 |->
            outc.regw.en == (op[5:3] != 3'h6);
    endproperty
    a_port: assert property (p_port) else $error("port input");
    property p_blk;
        ed && (op == 8'hB2 || op == 8'hB3) |-> tstates == (s_ff.c.b == 8'h01
            ? 5'h10 : 5'h15) && outc.f[`BJC_FZ] == (s_ff.c.b == 8'h01)
            && outc.f[`BJC_FN] == (op[0] ? s_ff.d[7] : s_ff.p[7]);
    endproperty
    a_blk: assert property (p_blk) else $error("block");
    property p_cnt;
        $rose(done) |-> cnt_ff == tstates;
    endproperty
    a_cnt: assert property (p_cnt) else $error("done timing");
    c_last: cover property (ed && op == 8'hB2 && s_ff.c.b == 8'h01);
    c_taken: cover property (np && op == 8'h38 && s_ff.c.f[`BJC_FC]);
    c_b2b: cover property (done && acc);
endmodule
bind bjc_decoder bjc_decoder_properties chk_u (.mclk(mclk), .resetn(resetn),
    .ce(ce), .ins_valid(ins_valid), .ins_ready(ins_ready), .ins(ins),
    .cpu(cpu), .opnd_rd(opnd_rd), .port_rd(port_rd), .stack_rd(stack_rd),
    .done(done), .tstates(tstates), .outc(outc));

// ==== sim/testbench.sv ====
// random self-checking decoder bench
// assumes: all other files compiled first
`include "bjc_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, resetn, ce, ins_valid, ins_ready, done, use_mem;
    bjc_pkg::bjc_ins_s ins;
    bjc_pkg::bjc_cpu_s cpu;
    bjc_pkg::bjc_outc_s outc;
    logic [7:0] opnd_rd, port_rd, mem_b, reg_b, x;
    logic [15:0] stack_rd;
    logic [4:0] tstates;
    logic [20:0] ex;
    logic [2:0] low3 [4] = '{3'h2, 3'h4, 3'h0, 3'h7};
    int err_total, samples_checked, seed, n, cls;
    // (HL) bytes from the model
    assign opnd_rd = use_mem ? mem_b : reg_b;
    bjc_bus_model mdl_u (.hl(cpu.hl), .sp(cpu.sp), .mem_byte(mem_b),
        .port_byte(port_rd), .stack_word(stack_rd));
    bjc_decoder dut_u (.mclk(mclk), .resetn(resetn), .ce(ce),
        .ins_valid(ins_valid), .ins_ready(ins_ready), .ins(ins), .cpu(cpu),
        .opnd_rd(opnd_rd), .port_rd(port_rd), .stack_rd(stack_rd),
        .done(done), .tstates(tstates), .outc(outc));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic met(input logic [2:0] c, input logic [7:0] f);
        logic b;
        b = c[2] ? (c[1] ? f[`BJC_FS] : f[`BJC_FP])
            : (c[1] ? f[`BJC_FC] : f[`BJC_FZ]);
        return c[0] ? b : !b;
    endfunction
    // expected {states, next pc}
    function automatic logic [20:0] expect_of(input bjc_pkg::bjc_ins_s i,
        input bjc_pkg::bjc_cpu_s c, input logic [15:0] w);
        logic m, r;
        logic [15:0] p2, p3;
        m = met(i.op[5:3], c.f);
        r = met({1'b0, i.op[4:3]}, c.f);
        p2 = c.pc + 16'h0002;
        p3 = c.pc + 16'h0003;
        if (i.pfx == 8'hCB)
            return {(i.op[2:0] != 3'h6 ? 5'h08
                : i.op[7:6] == 2'h1 ? 5'h0C : 5'h0F), p2};
        if (i.pfx == 8'hED)
            case (i.op)
                8'h6F, 8'h67: return {5'h12, p2};
                8'h45: return {5'h0E, w};
                8'hB2, 8'hB3: return c.b == 8'h01 ? {5'h10, p2} : {5'h15, c.pc};
                default: return {5'h0C, p2};
            endcase
        case (i.op[2:0])
            3'h2: return {5'h0A, (m ? i.imm : p3)};
            3'h4: return {(m ? 5'h11 : 5'h0A), (m ? i.imm : p3)};
            3'h7: return {5'h0B, 10'h000, i.op[5:3], 3'h0};
            default:
                if (i.op[7:6] == 2'h3)
                    return {(m ? 5'h0B : 5'h05), (m ? w : c.pc + 16'h0001)};
                else
                    return {(r ? 5'h0C : 5'h07), p2
                        + (r ? {{8{i.imm[7]}}, i.imm[7:0]} : 16'h0000)};
        endcase
    endfunction
    // a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_total++;
        print_verdict();
    end
    initial
    begin
        seed = 32'h582B5932;
        {resetn, ins_valid, use_mem, ce} = 4'h1;
        ins = '0;
        cpu = '0;
        reg_b = 8'h00;
        repeat (12) @(posedge mclk);
        #1 resetn = 1'b1;
        // each class twice, then random
        for (int k = 0; k < 300; k++)
        begin
            x = 8'($random(seed));
            cls = k < 22 ? k % 11 : ($random(seed) & 32'h7FFF) % 11;
            cpu = 73'({$random(seed), $random(seed), $random(seed)});
            ins.imm = 16'($random(seed));
            reg_b = 8'($random(seed));
            if (k < 22)
                ins.imm[7:0] = k[0] ? 8'h80 : 8'h7F;
            if (k > 10 && k < 22)
                cpu.b = 8'h01;
            case (cls)
                0: {ins.pfx, ins.op} = x[0] ? 16'hED6F : 16'hED67;
                1: {ins.pfx, ins.op} = 16'hED45;
                2: {ins.pfx, ins.op} = x[0] ? 16'hEDB3 : 16'hEDB2;
                3: {ins.pfx, ins.op} = {8'hED, 2'h1, x[5:3], 3'h0};
                4: {ins.pfx, ins.op} = {8'hCB, 2'h1, x[5:0]};
                5: {ins.pfx, ins.op} = {8'hCB, (x[6] ? 2'h3 : 2'h2), x[5:0]};
                10: {ins.pfx, ins.op} = {8'h00, 3'h1, x[4:3], 3'h0};
                default:
                    {ins.pfx, ins.op} = {8'h00, 2'h3, x[5:3], low3[cls-6]};
            endcase
            use_mem = ins.pfx == 8'hED || ins.op[2:0] == 3'h6;
            ins_valid = 1'b1;
            ce = 1'b1;
            @(posedge mclk);
            #1 ins_valid = 1'b0;
            ex = expect_of(ins, cpu, stack_rd);
            chk(16'(tstates), 16'(ex[20:16]));
            chk(outc.pc, ex[15:0]);
            if (cls == 0)
                chk(16'(outc.a[7:4]), 16'(cpu.a[7:4]));
            if (cls == 1)
                chk(16'({outc.ien_ld, outc.ien_val}),
                    16'({1'b1, cpu.ien2}));
            if (cls == 2)
                chk(16'({outc.f[`BJC_FZ], outc.f[`BJC_FN]}),
                    16'({cpu.b == 8'h01,
                    (ins.op[0] ? opnd_rd[7] : port_rd[7])}));
            if (cls == 3)
                chk(16'(outc.regw.en), 16'(ins.op[5:3] != 3'h6));
            if (cls == 4)
                chk(16'(outc.f[`BJC_FZ]), 16'(!opnd_rd[ins.op[5:3]]));
            if (cls == 5 && ins.op[7:6] == 2'h2)
                chk(16'(outc.f), 16'(cpu.f));
            if (cls == 5 && ins.op[7:6] == 2'h2 && !use_mem)
                chk(16'(outc.regw.data),
                    16'(opnd_rd & ~(8'h01 << ins.op[5:3])));
            // count enabled edges to done, ce stalling
            n = 0;
            for (int g = 0; g < 80 && done !== 1'b1; g++)
            begin
                ce = ($random(seed) & 7) != 0;
                @(posedge mclk);
                n = n + int'(ce);
                #1;
            end
            chk(16'(n), 16'(ex[20:16]));
        end
        print_verdict();
    end
endmodule
